//--- design/nvc_host_ctrl.sv
// Purpose: host-side controller driving an 8K x 8 nvsram over its pins
// Assumes: AXI4-Lite register slave, dq and store-busy sampled synchronously
// Notes:   one memory operation at a time; commands while busy are dropped
// Summary of operation
// - host keeps the address stable across the whole write strobe.
// - host keeps output-on high through every write.
// - six chip-select reads 0000,1555,0AAA,1FFF,10F0,0F0F start a store.
// - every sequence step is a read; output-on level does not matter.
// - same five reads then 0F0E start a recall.
// - the power configuration is chosen once and never switched.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
module nvc_host_ctrl
    import nvc_pkg::*;
#(
    parameter nvc_cnt_t NV_SAVE_COUNT = NV_SAVE_CYC,
    parameter nvc_cnt_t POWERUP_COUNT = POWERUP_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire nvc_axi_req_s  axi_i,
    output nvc_axi_rsp_s       axi_o,
    output nvc_mem_out_s       mem_o,
    input  wire logic [7:0]    mem_dq_i,
    input  wire logic          mem_hsb_i
);
    typedef enum logic [3:0] {
        S_PWRUP, S_IDLE, S_SETUP, S_STROBE, S_END, S_NV_WAIT,
        S_HW_PULSE, S_HW_SENSE, S_HSB_WAIT, S_RECOVER
    } nvc_state_e;

    nvc_state_e   state_q, state_d;
    nvc_op_e      op_q;
    nvc_mode_e    mode_q;
    logic [2:0]   seq_idx_q;
    logic [12:0]  addr_reg_q;
    logic [7:0]   wdata_reg_q;
    logic [7:0]   rdata_q;
    logic         dirty_q;
    logic         mode_lock_q;
    logic         cmd_err_q;
    nvc_mem_out_s mem_q, mem_d;
    nvc_axi_rsp_s rsp_q;
    logic [7:0]   awaddr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;

    logic         t_load;
    nvc_cnt_t     t_value;
    logic         t_done;

    nvc_wait_timer #(
        .RST_COUNT (POWERUP_COUNT)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (t_load),
        .value    (t_value),
        .done     (t_done)
    );

    // register write decode
    wire       wr_fire  = !rsp_q.awready && !rsp_q.wready && !rsp_q.bvalid;
    wire       wr_cmd   = wr_fire && awaddr_q == REG_CMD && wstrb_q[0];
    wire       wr_addr  = wr_fire && awaddr_q == REG_ADDR;
    wire       wr_wdat  = wr_fire && awaddr_q == REG_WDATA && wstrb_q[0];
    wire       wr_mode  = wr_fire && awaddr_q == REG_MODE && wstrb_q[0];
    wire       wr_ok    = awaddr_q inside {REG_CMD, REG_ADDR, REG_WDATA,
                                           REG_MODE};
    wire       rd_fire  = axi_i.arvalid && rsp_q.arready;
    wire       rd_ok    = axi_i.araddr inside {REG_CMD, REG_ADDR, REG_WDATA,
                                               REG_STATUS, REG_RDATA,
                                               REG_MODE};
    wire nvc_op_e cmd_op = nvc_op_e'(wdata_q[2:0]);
    wire       busy     = state_q != S_IDLE;
    wire       cmd_go   = wr_cmd && !busy && cmd_op != OP_NONE
                          && cmd_op <= OP_HW_STORE;
    wire       is_seq   = op_q inside {OP_SW_STORE, OP_SW_RECALL};
    wire       seq_done = is_seq && seq_idx_q == SEQ_LAST;
    wire [31:0] status  = {27'h0, cmd_err_q, mode_lock_q, mem_hsb_i,
                           dirty_q, busy};
    wire [31:0] rd_mux  =
        (axi_i.araddr == REG_CMD)    ? {29'h0, op_q} :
        (axi_i.araddr == REG_ADDR)   ? {19'h0, addr_reg_q} :
        (axi_i.araddr == REG_WDATA)  ? {24'h0, wdata_reg_q} :
        (axi_i.araddr == REG_STATUS) ? status :
        (axi_i.araddr == REG_RDATA)  ? {24'h0, rdata_q} :
        (axi_i.araddr == REG_MODE)   ? {30'h0, mode_q} : 32'h0;

    // sequencer
    always_comb begin
        state_d = state_q;
        t_load  = 1'b0;
        t_value = '0;
        unique case (state_q)
            S_PWRUP: begin
                if (t_done && mem_hsb_i) begin
                    state_d = S_IDLE;
                end
            end
            S_IDLE: begin
                if (!mem_hsb_i) begin
                    state_d = S_HSB_WAIT;
                end else if (cmd_go && cmd_op == OP_HW_STORE) begin
                    state_d = S_HW_PULSE;
                    t_load  = 1'b1;
                    t_value = HW_PULSE_CYC - nvc_cnt_t'(1);
                end else if (cmd_go) begin
                    state_d = S_SETUP;
                end
            end
            S_SETUP: begin
                state_d = S_STROBE;
                t_load  = 1'b1;
                t_value = STROBE_CYC - nvc_cnt_t'(1);
            end
            S_STROBE: begin
                if (t_done) begin
                    state_d = S_END;
                end
            end
            S_END: begin
                if (seq_done) begin
                    state_d = S_NV_WAIT;
                    t_load  = 1'b1;
                    t_value = (op_q == OP_SW_STORE) ? NV_SAVE_COUNT
                                                    : SW_LOAD_CYC;
                end else if (is_seq) begin
                    state_d = S_SETUP;
                end else begin
                    state_d = S_IDLE;
                end
            end
            S_NV_WAIT: begin
                if (t_done) begin
                    state_d = S_HSB_WAIT;
                end
            end
            S_HW_PULSE: begin
                if (t_done) begin
                    state_d = S_HW_SENSE;
                    t_load  = 1'b1;
                    t_value = HSB_SENSE_CYC;
                end
            end
            S_HW_SENSE: begin
                if (t_done || !mem_hsb_i) begin
                    state_d = S_HSB_WAIT;
                end
            end
            S_HSB_WAIT: begin
                if (mem_hsb_i) begin
                    state_d = S_RECOVER;
                    t_load  = 1'b1;
                    t_value = RECOVER_CYC;
                end
            end
            S_RECOVER: begin
                if (t_done) begin
                    state_d = S_IDLE;
                end
            end
        endcase
    end

    // pin image registered so every pin comes straight from a flop
    wire       op_wr    = op_q == OP_WRITE;
    wire       drv_act  = state_d inside {S_SETUP, S_STROBE, S_END};
    // op_q is stale in idle; the new command decides the first cycle
    wire       from_idl = state_q == S_IDLE;
    wire       seq_next = from_idl ? cmd_op inside {OP_SW_STORE, OP_SW_RECALL}
                                   : is_seq;
    wire [2:0] idx_next = from_idl ? 3'h0 : seq_idx_q + 3'h1;
    wire       wr_next  = from_idl ? cmd_op == OP_WRITE : op_wr;
    always_comb begin
        mem_d          = mem_q;
        mem_d.ce_n     = state_d != S_STROBE;
        mem_d.we_n     = !(state_d == S_STROBE && op_wr);
        mem_d.oe_n     = !(state_d == S_STROBE && op_q == OP_READ);
        mem_d.dq_oe_n  = !(drv_act && wr_next);
        mem_d.dq_o     = wdata_reg_q;
        mem_d.hsb_o    = 1'b0;
        mem_d.hsb_oe_n = state_d != S_HW_PULSE;
        if (state_d == S_SETUP) begin
            // address only moves outside the strobe
            mem_d.addr = seq_next ? seq_addr(idx_next, op_q == OP_SW_RECALL)
                                  : addr_reg_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_PWRUP;
            mem_q   <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                         dq_o: '0, dq_oe_n: 1'b1, hsb_o: 1'b0,
                         hsb_oe_n: 1'b1};
        end else begin
            state_q <= state_d;
            mem_q   <= mem_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q      <= OP_NONE;
            seq_idx_q <= '0;
        end else if (state_q == S_IDLE && cmd_go) begin
            op_q      <= cmd_op;
            seq_idx_q <= '0;
        end else if (state_q == S_END && is_seq && !seq_done) begin
            seq_idx_q <= seq_idx_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (state_q == S_STROBE && t_done && op_q == OP_READ) begin
            rdata_q <= mem_dq_i;
        end
    end

    // written-since-last-cycle tracker, cleared by a software store or recall, by OP_HW_STORE, and by any store-busy wait outside inhibit mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dirty_q <= 1'b0;
        end else if (state_q == S_END && op_wr) begin
            dirty_q <= 1'b1;
        end else if (state_q == S_NV_WAIT) begin
            dirty_q <= 1'b0;
        end else if (state_q == S_HSB_WAIT && mode_q != MODE_INHIBIT) begin
            dirty_q <= 1'b0;
        end else if (state_q == S_HSB_WAIT && op_q == OP_HW_STORE) begin
            dirty_q <= 1'b0;
        end
    end

    // register file; mode locks after its first write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg_q  <= '0;
            wdata_reg_q <= '0;
            mode_q      <= MODE_RST;
            mode_lock_q <= 1'b0;
            cmd_err_q   <= 1'b0;
        end else begin
            if (wr_addr && wstrb_q[0]) begin
                addr_reg_q[7:0] <= wdata_q[7:0];
            end
            if (wr_addr && wstrb_q[1]) begin
                addr_reg_q[12:8] <= wdata_q[12:8];
            end
            if (wr_wdat) begin
                wdata_reg_q <= wdata_q[7:0];
            end
            if (wr_mode && !mode_lock_q) begin
                mode_q      <= nvc_mode_e'(wdata_q[1:0]);
                mode_lock_q <= 1'b1;
            end
            if (wr_cmd) begin
                cmd_err_q <= !cmd_go;
            end
        end
    end

    // AXI4-Lite slave channels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q    <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                          bresp: RESP_OKAY, rresp: RESP_OKAY, default: '0};
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else begin
            if (axi_i.awvalid && rsp_q.awready) begin
                awaddr_q      <= axi_i.awaddr;
                rsp_q.awready <= 1'b0;
            end
            if (axi_i.wvalid && rsp_q.wready) begin
                wdata_q      <= axi_i.wdata;
                wstrb_q      <= axi_i.wstrb;
                rsp_q.wready <= 1'b0;
            end
            if (wr_fire) begin
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (rsp_q.bvalid && axi_i.bready) begin
                rsp_q.bvalid  <= 1'b0;
                rsp_q.awready <= 1'b1;
                rsp_q.wready  <= 1'b1;
            end
            if (rd_fire) begin
                rsp_q.arready <= 1'b0;
                rsp_q.rvalid  <= 1'b1;
                rsp_q.rdata   <= rd_mux;
                rsp_q.rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (rsp_q.rvalid && axi_i.rready) begin
                rsp_q.rvalid  <= 1'b0;
                rsp_q.arready <= 1'b1;
            end
        end
    end

    assign axi_o = rsp_q;
    assign mem_o = mem_q;
endmodule // nvc_host_ctrl

//--- design/nvc_pkg.sv
// Purpose: shared constants, types and helpers of the nvsram host controller
// Assumes: core_clk at 200 MHz
// Notes:   times kept in their own unit, cycle counts derived from them
package nvc_pkg;

    localparam int CLK_NS       = 5;
    localparam int STROBE_NS    = 55;   // chip-select low time per access
    localparam int HW_PULSE_NS  = 15;   // least store-request pulse
    localparam int HSB_SENSE_NS = 300;  // request to busy answer, longest
    localparam int RECOVER_NS   = 700;  // busy release to access allowed
    localparam int SW_LOAD_US   = 20;   // sw_load_time
    localparam int NV_SAVE_MS   = 10;   // nv_save_time
    localparam int POWERUP_US   = 550;  // powerup_load_time

    typedef logic [20:0] nvc_cnt_t;

    function automatic int ceil_cyc(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    localparam nvc_cnt_t STROBE_CYC    = nvc_cnt_t'(ceil_cyc(STROBE_NS));
    localparam nvc_cnt_t HW_PULSE_CYC  = nvc_cnt_t'(ceil_cyc(HW_PULSE_NS));
    localparam nvc_cnt_t HSB_SENSE_CYC = nvc_cnt_t'(ceil_cyc(HSB_SENSE_NS));
    localparam nvc_cnt_t RECOVER_CYC   = nvc_cnt_t'(ceil_cyc(RECOVER_NS));
    localparam nvc_cnt_t SW_LOAD_CYC   =
        nvc_cnt_t'(ceil_cyc(SW_LOAD_US * 1000));
    localparam nvc_cnt_t NV_SAVE_CYC   =
        nvc_cnt_t'(ceil_cyc(NV_SAVE_MS * 1000000));
    localparam nvc_cnt_t POWERUP_CYC   =
        nvc_cnt_t'(ceil_cyc(POWERUP_US * 1000));

    // unlock sequence addresses
    localparam logic [12:0] SEQ_A0      = 13'h0000;
    localparam logic [12:0] SEQ_A1      = 13'h1555;
    localparam logic [12:0] SEQ_A2      = 13'h0AAA;
    localparam logic [12:0] SEQ_A3      = 13'h1FFF;
    localparam logic [12:0] SEQ_A4      = 13'h10F0;
    localparam logic [12:0] SEQ_STORE   = 13'h0F0F;
    localparam logic [12:0] SEQ_RECALL  = 13'h0F0E;
    localparam logic [2:0]  SEQ_LAST    = 3'h5;

    // register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_MODE   = 8'h14;

    // status fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_DIRTY_BIT  = 1;
    localparam int ST_HSB_BIT    = 2;
    localparam int ST_LOCK_BIT   = 3;
    localparam int ST_ERR_BIT    = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_NONE, OP_READ, OP_WRITE, OP_SW_STORE, OP_SW_RECALL, OP_HW_STORE
    } nvc_op_e;

    typedef enum logic [1:0] {
        MODE_AUTO, MODE_SYSPWR, MODE_INHIBIT
    } nvc_mode_e;

    localparam nvc_mode_e MODE_RST = MODE_AUTO;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } nvc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } nvc_axi_rsp_s;

    typedef struct packed {
        logic [12:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [7:0]  dq_o;
        logic        dq_oe_n;
        logic        hsb_o;
        logic        hsb_oe_n;
    } nvc_mem_out_s;

    function automatic logic [12:0] seq_addr(input logic [2:0] idx,
                                             input logic recall);
        case (idx)
            3'h0:    return SEQ_A0;
            3'h1:    return SEQ_A1;
            3'h2:    return SEQ_A2;
            3'h3:    return SEQ_A3;
            3'h4:    return SEQ_A4;
            default: return recall ? SEQ_RECALL : SEQ_STORE;
        endcase
    endfunction

endpackage

//--- design/nvc_wait_timer.sv
// Purpose: down counter for the access and nonvolatile wait phases
// Assumes: load wins over counting
// Notes:   done is high while the count rests at zero
module nvc_wait_timer
    import nvc_pkg::*;
#(
    parameter nvc_cnt_t RST_COUNT = '0
) (
    input  wire logic     core_clk,
    input  wire logic     rst_n,
    input  wire logic     load,
    input  wire nvc_cnt_t value,
    output logic          done
);
    nvc_cnt_t cnt_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= RST_COUNT;
        end else if (load) begin
            cnt_q <= value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - nvc_cnt_t'(1);
        end
    end

    assign done = (cnt_q == '0);
endmodule // nvc_wait_timer

//--- verif/nvc_host_asserts.sv
// Purpose: port-level checks of the nvsram host controller
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   bound to the controller from the bench top file
module nvc_host_asserts
    import nvc_pkg::*;
#(
    parameter nvc_cnt_t NV_SAVE_COUNT = NV_SAVE_CYC,
    parameter nvc_cnt_t POWERUP_COUNT = POWERUP_CYC
) (
    input wire logic         core_clk,
    input wire logic         rst_n,
    input wire nvc_axi_req_s axi_i,
    input wire nvc_axi_rsp_s axi_o,
    input wire nvc_mem_out_s mem_o,
    input wire logic [7:0]   mem_dq_i,
    input wire logic         mem_hsb_i
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // saturates so it never wraps on long runs
    nvc_cnt_t pu_cnt_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) pu_cnt_q <= '0;
        else if (pu_cnt_q <= POWERUP_COUNT) pu_cnt_q <= pu_cnt_q + 1'b1;
    end

    sequence cs_low11;
        (!mem_o.ce_n)[*8] ##1 (!mem_o.ce_n)[*3];
    endsequence
    sequence pull3;
        (!mem_o.hsb_oe_n && !mem_o.hsb_o)[*3];
    endsequence
    sequence aw_w_taken;
        axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready;
    endsequence

    AST_WR_ADDR_HOLD: assert property (
        (!mem_o.ce_n && !mem_o.we_n) |=> $stable(mem_o.addr))
        else $error("address moved during a write strobe");
    AST_WR_OE_HIGH: assert property (
        !mem_o.we_n |-> mem_o.oe_n)
        else $error("output-on low during a write");
    AST_WR_IN_CS: assert property (
        !mem_o.we_n |-> !mem_o.ce_n && !mem_o.dq_oe_n)
        else $error("write strobe without select or data drive");
    AST_RD_NO_DRIVE: assert property (
        !mem_o.oe_n |-> mem_o.dq_oe_n && mem_o.we_n)
        else $error("data driven while output-on low");
    AST_CS_PULSE: assert property (
        $fell(mem_o.ce_n) |-> cs_low11 ##1 mem_o.ce_n)
        else $error("chip select low time not eleven cycles");
    AST_PIN_REQ: assert property (
        $fell(mem_o.hsb_oe_n) |-> pull3 ##1 mem_o.hsb_oe_n)
        else $error("store request pull not three cycles");
    AST_PU_WAIT: assert property (
        !mem_o.ce_n |-> pu_cnt_q > POWERUP_COUNT)
        else $error("access before power-up load time");
    AST_B_RESP: assert property (
        aw_w_taken |-> ##[1:2] axi_o.bvalid)
        else $error("write response late");
    AST_B_REFUSE: assert property (
        axi_o.bvalid |-> !axi_o.awready && !axi_o.wready)
        else $error("write accepted while response pending");
    AST_R_REFUSE: assert property (
        axi_o.rvalid |-> !axi_o.arready)
        else $error("read accepted while data pending");

endmodule // nvc_host_asserts

//--- verif/nvc_dev_model.sv
// Purpose: behavioural 8K x 8 nvsram with shadow copy
// Assumes: pins change after core_clk rise, sampled here on the fall
// Notes:   free data lines toggle every cycle instead of holding
module nvc_dev_model
    import nvc_pkg::*;
#(
    parameter nvc_mode_e MODE     = MODE_AUTO,
    parameter int        SAVE_CYC = 40,
    parameter int        LOAD_CYC = 100,
    parameter int        PU_CYC   = 15,
    parameter int        RD_LAT   = 6
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire nvc_mem_out_s mem,
    input  wire logic [7:0]   dq_in,
    input  wire logic         hsb_in,
    input  wire logic         pwr_fail,
    output logic [7:0]        dq,
    output logic              hsb_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [12:0] SQ [6] = '{13'h0000, 13'h1555, 13'h0AAA,
                                       13'h1FFF, 13'h10F0, 13'h0F0F};
    logic [7:0] sram [8192];
    logic [7:0] nv [8192];
    logic       pend;
    logic       dirty;
    logic       pce_n;
    logic       pwe_n;
    logic       rd_act;
    int         busy;
    int         step;
    int         rd_cnt;
    int         n_store;

    // store: nv takes sram image; recall: sram reloaded, nv untouched
    task automatic nv_xfer(input bit st);
        for (int i = 0; i < 8192; i++) begin
            if (st) nv[i] = sram[i];
            else sram[i] = nv[i];
        end
        busy = st ? SAVE_CYC : LOAD_CYC;
        hsb_pull = st;
        n_store += st;
        dirty = 1'b0;
        step = 0;
    endtask

    initial begin
        dq = 8'h00;
        hsb_pull = 1'b0;
        n_store = 0;
        dirty = 1'b0;
        rd_cnt = 0;
        foreach (nv[i]) nv[i] = 8'h00;
    end

    assign rd_act = !mem.ce_n && !mem.oe_n && mem.we_n && hsb_in
                    && busy == 0 && !pend;

    always @(negedge core_clk) begin
        if (!rst_n) begin
            pend = 1'b1;
            busy = 0;
            step = 0;
            hsb_pull = 1'b0;
        end else if (busy > 0) begin
            busy--;
            if (busy == 0) hsb_pull = 1'b0;
        end else if (pend) begin
            pend = 1'b0;
            nv_xfer(1'b0);
            busy = PU_CYC;
        end else if (!hsb_in && dirty) begin
            nv_xfer(1'b1);
        end else if (pwr_fail && MODE != MODE_INHIBIT && dirty) begin
            nv_xfer(1'b1);
        end else if (pce_n && !mem.ce_n) begin
            if (!mem.we_n) step = 0;
            else if (step == 5 && mem.addr == 13'h0F0E) nv_xfer(1'b0);
            else if (mem.addr == SQ[step] && step == 5) nv_xfer(1'b1);
            else if (mem.addr == SQ[step]) step++;
            else step = 0;
        end else if (!pce_n && !pwe_n && hsb_in && (mem.ce_n || mem.we_n)) begin
            sram[mem.addr] = dq_in;
            dirty = 1'b1;
        end
        pce_n = mem.ce_n;
        pwe_n = mem.we_n;
        rd_cnt = rd_act ? rd_cnt + 1 : 0;
        dq = (rd_act && rd_cnt > RD_LAT) ? sram[mem.addr] : ~dq;
    end

endmodule // nvc_dev_model

//--- verif/nvc_host_ctrl_tb.sv
// Purpose: self-checking bench of the nvsram host controller
// Assumes: shortened save and power-up counts, device model far side
// Notes:   all traffic goes through the register bus
module nvc_host_ctrl_tb
    import nvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam nvc_cnt_t    PU_N     = 20;
    localparam nvc_cnt_t    SAVE_N   = 50;
    localparam logic [12:0] ADR [3]  = '{13'h0000, 13'h1234, 13'h1FFF};
    localparam logic [7:0]  DAT [3]  = '{8'hA5, 8'h3C, 8'h5A};
    logic         core_clk = 1'b0;
    logic         rst_n    = 1'b0;
    logic         pwr_fail = 1'b0;
    nvc_axi_req_s req      = '0;
    nvc_axi_rsp_s rsp;
    nvc_mem_out_s mem;
    logic [7:0]   dev_dq;
    logic [7:0]   dq_bus;
    logic         dev_pull;
    logic         hsb_w;
    logic [31:0]  s;
    int           n_mismatch = 0;
    int           compares   = 0;
    int           n0;

    always #2.5 core_clk = ~core_clk;
    assign dq_bus = mem.dq_oe_n ? dev_dq : mem.dq_o;
    // pull-up on store-busy: low while either side pulls
    assign hsb_w = !(dev_pull || (!mem.hsb_oe_n && !mem.hsb_o));

    nvc_host_ctrl #(.NV_SAVE_COUNT(SAVE_N), .POWERUP_COUNT(PU_N)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .axi_i(req), .axi_o(rsp),
        .mem_o(mem), .mem_dq_i(dq_bus), .mem_hsb_i(hsb_w));
    nvc_dev_model #(.MODE(MODE_AUTO)) u_dev (
        .core_clk(core_clk), .rst_n(rst_n), .mem(mem), .dq_in(dq_bus),
        .hsb_in(hsb_w), .pwr_fail(pwr_fail), .dq(dev_dq),
        .hsb_pull(dev_pull));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        bit aw_done = 1'b0;
        bit w_done = 1'b0;
        @(posedge core_clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk);
            if (!aw_done && rsp.awready) begin
                aw_done = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!w_done && rsp.wready) begin
                w_done = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (!rsp.bvalid);
        req.bready <= 1'b0;
        check(rsp.bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge core_clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge core_clk); while (!rsp.rvalid);
        req.rready <= 1'b0;
        d = rsp.rdata;
        check(rsp.rresp, er);
    endtask

    // issue one memory command, then poll until the controller is idle
    task automatic mop(input logic [2:0] op);
        wr(REG_CMD, {29'h0, op});
        repeat (2) @(posedge core_clk);
        do rd(REG_STATUS, s); while (s[ST_BUSY_BIT]);
    endtask

    task automatic mem_wr(input logic [12:0] a, input logic [7:0] d);
        wr(REG_ADDR, {19'h0, a});
        wr(REG_WDATA, {24'h0, d});
        mop(3'h2);
    endtask

    task automatic mem_rd(input logic [12:0] a, input logic [7:0] e);
        wr(REG_ADDR, {19'h0, a});
        mop(3'h1);
        rd(REG_RDATA, s);
        check(s[7:0], e);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (PU_N + 10) @(posedge core_clk);
        rd(REG_STATUS, s);
        check(s[ST_BUSY_BIT], 1'b0);
        wr(REG_MODE, 32'h0);
        rd(REG_MODE, s);
        check(s[1:0], MODE_AUTO);
        rd(REG_STATUS, s);
        check(s[ST_LOCK_BIT], 1'b1);
        wr(REG_MODE, {30'h0, MODE_INHIBIT});
        rd(REG_MODE, s);
        check(s[1:0], MODE_AUTO);
        wr(8'h18, 32'h1, RESP_SLVERR);
        rd(8'h18, s, RESP_SLVERR);
        mop(3'h6);
        check(s[ST_ERR_BIT], 1'b1);
        for (int i = 0; i < 3; i++) begin
            mem_wr(ADR[i], DAT[i]);
            mem_rd(ADR[i], DAT[i]);
        end
        rd(REG_STATUS, s);
        check(s[ST_DIRTY_BIT], 1'b1);
        n0 = u_dev.n_store;
        mop(3'h3);
        check(u_dev.nv[13'h1234], 8'h3C);
        check(s[ST_DIRTY_BIT], 1'b0);
        mop(3'h3);
        check(u_dev.n_store, n0 + 2);
        mem_wr(13'h1234, 8'h77);
        mop(3'h4);
        mem_rd(13'h1234, 8'h3C);
        mop(3'h5);
        check(u_dev.n_store, n0 + 2);
        mem_wr(13'h1FFF, 8'hC3);
        mop(3'h5);
        check(u_dev.nv[13'h1FFF], 8'hC3);
        mem_wr(13'h0000, 8'hE1);
        pwr_fail <= 1'b1;
        repeat (4) @(posedge core_clk);
        pwr_fail <= 1'b0;
        rd(REG_STATUS, s);
        check(s[ST_HSB_BIT], 1'b0);
        do rd(REG_STATUS, s); while (!s[ST_HSB_BIT]);
        repeat (150) @(posedge core_clk);
        check(u_dev.n_store, n0 + 4);
        mem_rd(13'h0000, 8'hE1);
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end

endmodule // nvc_host_ctrl_tb

bind nvc_host_ctrl nvc_host_asserts #(
    .NV_SAVE_COUNT(NV_SAVE_COUNT), .POWERUP_COUNT(POWERUP_COUNT)
) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .axi_i(axi_i), .axi_o(axi_o),
    .mem_o(mem_o), .mem_dq_i(mem_dq_i), .mem_hsb_i(mem_hsb_i));
